// file: hdl/sofc_formatter.v
/*
 * Output formatting stage of the serial pixel port: readout timing in
 * pixel periods, control word build, channel duplication, training word
 * fill, test pin mirroring and serialisation of 16 data lanes plus one
 * control lane with a forwarded DDR clock.
 * Assumes pixel data, frame request and exposure status come from logic
 * on clk_sys; the input pixel clock is asynchronous and is sampled.
 */
`timescale 1ns/1ps
`include "sofc_regs.vh"

// Notes on behaviour
// - All 16 data lanes always driven; unused ones repeat a selected channel.
// - 16 mode own channel; 8 mode odd copied; 2 mode channels 1 and 9.
// - 4 mode repeats channels 1, 5, 9, 13 over groups of four lanes.
// - One extra serial control lane tells the receiver when data is valid.
// - Control words have the selected 10 or 12 bit width, in step.
// - Control bit 0 high exactly when data lanes carry valid pixels.
// - Control bit 1 high for the duration of a row readout.
// - Control bit 2 high for the duration of a frame readout.
// - Control bit 3 flags the one pixel overhead before each burst.
// - Control bit 4 flags the overhead period before each row.
// - Control bit 5 high while frame overhead samples pixel charge.
// - Control bits 6 and 7 flag integration of blocks A and B.
// - Bits 8, 10, 11 zero, bit 9 one; idle word is 512.
// - Integration bits forced low while frame overhead bit is high.
// - Two test pins mirror a control bit picked by their own registers.
// - In reduced modes valid timing stretches with the longer row.
// - Training word on all data lanes whenever no valid pixels are sent.
// - Training word has pixel width, value from 12 bit two address register.
// - Control lane never carries the training word.
// - Words go LSB first, bit 0 in the forwarded clock high phase.
// - One pixel word per lane per input clock period.
// - Bursts of 128 pixels, each preceded by one pixel of overhead.
// - Selecting 12 bit width forces 4 lane multiplexing unless 2 mode is selected.
module sofc_formatter #(
    parameter ROWS      = `SOFC_ROWS_DEFAULT,
    parameter BURST_LEN = `SOFC_BURST_LEN
) (
    input  wire           clk_sys,
    input  wire           nrst,
    input  wire           pixClkIn,
    input  wire [1:0]     chanMode,
    input  wire           pixel12,
    input  wire           frameReq,
    input  wire           fotActive,
    input  wire           integratingBlockA,
    input  wire           integratingBlockB,
    input  wire [191:0]   pixIn,
    input  wire           regWrEn,
    input  wire [6:0]     regAddr,
    input  wire [7:0]     regWrData,
    output reg  [7:0]     regRdData,
    output wire [15:0]    dataLane,
    output wire           ctrlLane,
    output reg            forwardedDdrClock,
    output reg            testOutPinA,
    output reg            testOutPinB,
    output reg            pixelStrobe
);
    // Readout states
    localparam ST_IDLE   = 2'h0;
    localparam ST_ROWOH  = 2'h1;
    localparam ST_SLOTOH = 2'h2;
    localparam ST_BURST  = 2'h3;

    // Last counts cut to the counter widths on purpose
    localparam integer LAST_PIX_I = BURST_LEN - 1;
    localparam integer LAST_ROW_I = ROWS - 1;
    localparam [6:0]  LAST_PIX = LAST_PIX_I[6:0];
    localparam [11:0] LAST_ROW = LAST_ROW_I[11:0];

    reg  [11:0] trainWord_q;
    reg  [7:0]  tpinSelA_q;
    reg  [7:0]  tpinSelB_q;
    reg         pixClkPrev_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [6:0]  pixCnt_q;
    reg  [6:0]  pixCnt_d;
    reg  [2:0]  burstCnt_q;
    reg  [2:0]  burstCnt_d;
    reg  [11:0] rowCnt_q;
    reg  [11:0] rowCnt_d;
    reg         startPend_q;
    reg  [1:0]  mode_q;
    reg         wide_q;
    reg  [1:0]  modeEff;
    reg  [2:0]  lastBurst;
    reg  [11:0] ctrlWord_d;
    reg  [11:0] ctrlWord_q;
    reg  [191:0] laneWord_q;
    reg  [191:0] laneWord_d;
    reg         load_q;
    reg  [3:0]  bitCnt_q;
    reg  [3:0]  wordLen;
    reg         flagSelA;
    reg         flagSelB;
    reg  [4:0]  srcIdx;
    reg  [11:0] pixWord;
    wire        pixClkSync;
    wire        pixStb;
    integer     o;

    // Input pixel clock passes two flip-flops before edge detection
    sofc_sync u_clkSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn (pixClkIn),
        .syncOut (pixClkSync)
    );

    assign pixStb = pixClkSync & ~pixClkPrev_q;

    // Configuration write port and read-back of the addressed register
    always @(posedge clk_sys) begin
        if (!nrst) begin
            trainWord_q <= `SOFC_RST_TRAIN;
            tpinSelA_q  <= `SOFC_RST_TPIN_SEL;
            tpinSelB_q  <= `SOFC_RST_TPIN_SEL;
            regRdData   <= 8'h00;
        end else begin
            if (regWrEn) begin
                case (regAddr)
                    `SOFC_ADDR_TRAIN_LO: trainWord_q[7:0] <= regWrData;
                    `SOFC_ADDR_TRAIN_HI: trainWord_q[11:8] <= regWrData[3:0];
                    `SOFC_ADDR_TPIN1_SEL: tpinSelA_q <= regWrData;
                    `SOFC_ADDR_TPIN2_SEL: tpinSelB_q <= regWrData;
                    default: ;
                endcase
            end
            case (regAddr)
                `SOFC_ADDR_TRAIN_LO:  regRdData <= trainWord_q[7:0];
                `SOFC_ADDR_TRAIN_HI:  regRdData <= {4'h0, trainWord_q[11:8]};
                `SOFC_ADDR_TPIN1_SEL: regRdData <= tpinSelA_q;
                `SOFC_ADDR_TPIN2_SEL: regRdData <= tpinSelB_q;
                default:              regRdData <= 8'h00;
            endcase
        end
    end

    // Effective lane mode; wide pixels allow only 4 or 2 lanes
    always @* begin
        modeEff = chanMode;
        if (pixel12 && chanMode != `SOFC_MODE_2)
            modeEff = `SOFC_MODE_4;
    end

    // Bursts per row grow as lanes shrink, so valid windows stretch
    always @* begin
        case (mode_q)
            `SOFC_MODE_16: lastBurst = 3'h0;
            `SOFC_MODE_8:  lastBurst = 3'h1;
            `SOFC_MODE_4:  lastBurst = 3'h3;
            default:       lastBurst = 3'h7;
        endcase
    end

    // Readout sequence and the control word for the current pixel period
    always @* begin
        state_d    = state_q;
        pixCnt_d   = pixCnt_q;
        burstCnt_d = burstCnt_q;
        rowCnt_d   = rowCnt_q;
        ctrlWord_d = `SOFC_CTRL_IDLE;
        ctrlWord_d[`SOFC_BIT_FOT] = fotActive;
        // Exposure overlapping frame overhead is hidden from these bits
        ctrlWord_d[`SOFC_BIT_INTA] = integratingBlockA & ~fotActive;
        ctrlWord_d[`SOFC_BIT_INTB] = integratingBlockB & ~fotActive;
        case (state_q)
            ST_IDLE: begin
                if (startPend_q) begin
                    state_d  = ST_ROWOH;
                    rowCnt_d = 12'h000;
                end
            end
            ST_ROWOH: begin
                ctrlWord_d[`SOFC_BIT_FRAME_VALID_FLAG]  = 1'b1;
                ctrlWord_d[`SOFC_BIT_ROWOH] = 1'b1;
                state_d    = ST_SLOTOH;
                burstCnt_d = 3'h0;
            end
            ST_SLOTOH: begin
                ctrlWord_d[`SOFC_BIT_FRAME_VALID_FLAG] = 1'b1;
                ctrlWord_d[`SOFC_BIT_ROW_VALID_FLAG] = 1'b1;
                ctrlWord_d[`SOFC_BIT_SLOT] = 1'b1;
                state_d  = ST_BURST;
                pixCnt_d = 7'h00;
            end
            ST_BURST: begin
                // Valid bits nest: data inside row inside frame
                ctrlWord_d[`SOFC_BIT_FRAME_VALID_FLAG] = 1'b1;
                ctrlWord_d[`SOFC_BIT_ROW_VALID_FLAG] = 1'b1;
                ctrlWord_d[`SOFC_BIT_PIXEL_VALID_FLAG] = 1'b1;
                pixCnt_d = pixCnt_q + 7'h01;
                if (pixCnt_q == LAST_PIX) begin
                    if (burstCnt_q != lastBurst) begin
                        burstCnt_d = burstCnt_q + 3'h1;
                        state_d    = ST_SLOTOH;
                    end else if (rowCnt_q == LAST_ROW) begin
                        state_d = ST_IDLE;
                    end else begin
                        rowCnt_d = rowCnt_q + 12'h001;
                        state_d  = ST_ROWOH;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Lane words: duplicated channel data while valid, training otherwise
    always @* begin
        laneWord_d = 192'h0;
        srcIdx     = 5'h00;
        pixWord    = 12'h000;
        for (o = 0; o < 16; o = o + 1) begin
            case (mode_q)
                `SOFC_MODE_16: srcIdx = o[4:0];
                `SOFC_MODE_8:  srcIdx = o[4:0] & 5'h1E;
                `SOFC_MODE_4:  srcIdx = o[4:0] & 5'h1C;
                default:       srcIdx = o[4:0] & 5'h18;
            endcase
            pixWord = pixIn[srcIdx*12 +: 12];
            if (!ctrlWord_d[`SOFC_BIT_PIXEL_VALID_FLAG])
                pixWord = trainWord_q;
            if (!wide_q)
                pixWord = {2'h0, pixWord[9:0]};
            laneWord_d[o*12 +: 12] = pixWord;
        end
    end

    // Word length follows the latched pixel width
    always @* begin
        wordLen = wide_q ? `SOFC_LEN12 : `SOFC_LEN10;
    end

    // Sequence registers advance once per input clock period
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pixClkPrev_q <= 1'b0;
            state_q      <= ST_IDLE;
            pixCnt_q     <= 7'h00;
            burstCnt_q   <= 3'h0;
            rowCnt_q     <= 12'h000;
            startPend_q  <= 1'b0;
            mode_q       <= `SOFC_MODE_16;
            wide_q       <= 1'b0;
            ctrlWord_q   <= `SOFC_CTRL_IDLE;
            laneWord_q   <= 192'h0;
            load_q       <= 1'b0;
            pixelStrobe  <= 1'b0;
        end else begin
            pixClkPrev_q <= pixClkSync;
            load_q       <= pixStb;
            pixelStrobe  <= pixStb;
            // A request arriving as the frame starts is kept, not lost
            if (frameReq)
                startPend_q <= 1'b1;
            else if (pixStb && state_q == ST_IDLE)
                startPend_q <= 1'b0;
            if (pixStb) begin
                state_q    <= state_d;
                pixCnt_q   <= pixCnt_d;
                burstCnt_q <= burstCnt_d;
                rowCnt_q   <= rowCnt_d;
                ctrlWord_q <= ctrlWord_d;
                laneWord_q <= laneWord_d;
                // Mode changes only take effect between frames
                if (state_d == ST_IDLE) begin
                    mode_q <= modeEff;
                    wide_q <= pixel12;
                end
            end
        end
    end

    // Forwarded clock: high with bit 0, toggling every bit time
    always @(posedge clk_sys) begin
        if (!nrst) begin
            forwardedDdrClock <= 1'b0;
            bitCnt_q          <= 4'h0;
        end else if (load_q) begin
            forwardedDdrClock <= 1'b1;
            bitCnt_q          <= 4'h1;
        end else if (bitCnt_q != 4'h0 && bitCnt_q < wordLen) begin
            forwardedDdrClock <= ~forwardedDdrClock;
            bitCnt_q          <= bitCnt_q + 4'h1;
        end else begin
            // Clock parks low once the word is out
            forwardedDdrClock <= 1'b0;
            bitCnt_q          <= 4'h0;
        end
    end

    // Sixteen data lanes, LSB first
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : gLane
            sofc_serializer #(
                .WIDTH (12)
            ) u_ser (
                .clk_sys (clk_sys),
                .nrst    (nrst),
                .load    (load_q),
                .word    (laneWord_q[g*12 +: 12]),
                .serOut  (dataLane[g])
            );
        end
    endgenerate

    // Dedicated control lane carries status words only
    sofc_serializer #(
        .WIDTH (12)
    ) u_ctrlSer (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .load    (load_q),
        .word    (ctrlWord_q),
        .serOut  (ctrlLane)
    );

    // Test pin source decode; unknown codes show zero
    always @* begin
        case (tpinSelA_q)
            `SOFC_TSEL_INTA: flagSelA = ctrlWord_q[`SOFC_BIT_INTA];
            `SOFC_TSEL_INTB: flagSelA = ctrlWord_q[`SOFC_BIT_INTB];
            `SOFC_TSEL_PIXEL_VALID_FLAG: flagSelA = ctrlWord_q[`SOFC_BIT_PIXEL_VALID_FLAG];
            `SOFC_TSEL_ROW_VALID_FLAG: flagSelA = ctrlWord_q[`SOFC_BIT_ROW_VALID_FLAG];
            `SOFC_TSEL_FRAME_VALID_FLAG: flagSelA = ctrlWord_q[`SOFC_BIT_FRAME_VALID_FLAG];
            default:         flagSelA = 1'b0;
        endcase
        case (tpinSelB_q)
            `SOFC_TSEL_INTA: flagSelB = ctrlWord_q[`SOFC_BIT_INTA];
            `SOFC_TSEL_INTB: flagSelB = ctrlWord_q[`SOFC_BIT_INTB];
            `SOFC_TSEL_PIXEL_VALID_FLAG: flagSelB = ctrlWord_q[`SOFC_BIT_PIXEL_VALID_FLAG];
            `SOFC_TSEL_ROW_VALID_FLAG: flagSelB = ctrlWord_q[`SOFC_BIT_ROW_VALID_FLAG];
            `SOFC_TSEL_FRAME_VALID_FLAG: flagSelB = ctrlWord_q[`SOFC_BIT_FRAME_VALID_FLAG];
            default:         flagSelB = 1'b0;
        endcase
    end

    // Test pins registered so they come straight from flops
    always @(posedge clk_sys) begin
        if (!nrst) begin
            testOutPinA <= 1'b0;
            testOutPinB <= 1'b0;
        end else begin
            testOutPinA <= flagSelA;
            testOutPinB <= flagSelB;
        end
    end
endmodule

// file: hdl/sofc_regs.vh
/*
 * Constants of the output formatter: register addresses, reset values,
 * control word bit positions, source codes and readout geometry.
 * Included by the formatter top; definitions only.
 */
`ifndef SOFC_REGS_VH
`define SOFC_REGS_VH

// Register addresses on the configuration write port
`define SOFC_ADDR_TRAIN_LO   7'h4E
`define SOFC_ADDR_TRAIN_HI   7'h4F
`define SOFC_ADDR_TPIN1_SEL  7'h6C
`define SOFC_ADDR_TPIN2_SEL  7'h6D

// Reset values
`define SOFC_RST_TRAIN       12'h055
`define SOFC_RST_TPIN_SEL    8'h00

// Control word bit positions
`define SOFC_BIT_PIXEL_VALID_FLAG        0
`define SOFC_BIT_ROW_VALID_FLAG        1
`define SOFC_BIT_FRAME_VALID_FLAG        2
`define SOFC_BIT_SLOT        3
`define SOFC_BIT_ROWOH       4
`define SOFC_BIT_FOT         5
`define SOFC_BIT_INTA        6
`define SOFC_BIT_INTB        7
`define SOFC_CTRL_IDLE       12'h200

// Test pin source codes
`define SOFC_TSEL_INTA       8'h00
`define SOFC_TSEL_INTB       8'h01
`define SOFC_TSEL_PIXEL_VALID_FLAG       8'h02
`define SOFC_TSEL_ROW_VALID_FLAG       8'h03
`define SOFC_TSEL_FRAME_VALID_FLAG       8'h04

// Channel mode codes
`define SOFC_MODE_16         2'h0
`define SOFC_MODE_8          2'h1
`define SOFC_MODE_4          2'h2
`define SOFC_MODE_2          2'h3

// Readout geometry in pixel periods and rows; serial word lengths in bits
`define SOFC_BURST_LEN       128
`define SOFC_ROWS_DEFAULT    1088
`define SOFC_LEN10           4'hA
`define SOFC_LEN12           4'hC

`endif

// file: hdl/sofc_serializer.v
/*
 * One serial lane: loads a word and shifts it out LSB first, one bit
 * per clock. Assumes the load comes no faster than the word length.
 */
`timescale 1ns/1ps
module sofc_serializer #(
    parameter WIDTH = 12
) (
    input  wire             clk_sys,
    input  wire             nrst,
    input  wire             load,
    input  wire [WIDTH-1:0] word,
    output reg              serOut
);
    reg [WIDTH-1:0] shift_q;

    // Bit 0 leaves in the load cycle's successor, the rest follow
    always @(posedge clk_sys) begin
        if (!nrst) begin
            shift_q <= {WIDTH{1'b0}};
            serOut  <= 1'b0;
        end else if (load) begin
            serOut  <= word[0];
            shift_q <= {1'b0, word[WIDTH-1:1]};
        end else begin
            serOut  <= shift_q[0];
            shift_q <= {1'b0, shift_q[WIDTH-1:1]};
        end
    end
endmodule

// file: hdl/sofc_sync.v
/*
 * Two flip-flop synchroniser for one level from another clock domain.
 * Assumes the input is free of glitches longer than a clock period.
 */
`timescale 1ns/1ps
module sofc_sync (
    input  wire clk_sys,
    input  wire nrst,
    input  wire asyncIn,
    output reg  syncOut
);
    reg firstStage_q;

    // First stage feeds only the second stage
    always @(posedge clk_sys) begin
        if (!nrst) begin
            firstStage_q <= 1'b0;
            syncOut      <= 1'b0;
        end else begin
            firstStage_q <= asyncIn;
            syncOut      <= firstStage_q;
        end
    end
endmodule

// file: tb/sofc_formatter_properties.sv
/* Checker of the formatter's port timing: strobe, serial lanes, registers.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
`include "sofc_regs.vh"
module sofc_formatter_checker (
    input wire        clk_sys,
    input wire        nrst,
    input wire        regWrEn,
    input wire [6:0]  regAddr,
    input wire [7:0]  regWrData,
    input wire [7:0]  regRdData,
    input wire [15:0] dataLane,
    input wire        ctrlLane,
    input wire        forwardedDdrClock,
    input wire        pixelStrobe
);
    reg [4:0] sinceStb_q;
    // Cycles since the last load, saturating
    always @(posedge clk_sys) begin
        if (!nrst || pixelStrobe)
            sinceStb_q <= 5'h00;
        else if (sinceStb_q != 5'h1F)
            sinceStb_q <= sinceStb_q + 5'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    strobe_pulse_a: assert property (pixelStrobe |=> !pixelStrobe)
        else $error("pixel strobe longer than one cycle");
    ddr_phase_a: assert property (pixelStrobe |=>
        forwardedDdrClock ##1 !forwardedDdrClock)
        else $error("bit0 not in forwarded clock high phase");
    ctrl_bit8_a: assert property (
        pixelStrobe ##1 (!pixelStrobe)[*8] |=> !ctrlLane)
        else $error("control bit8 not zero");
    ctrl_bit9_a: assert property (
        pixelStrobe ##1 (!pixelStrobe)[*8] ##1 !pixelStrobe |=> ctrlLane)
        else $error("control bit9 not one");
    ctrl_bit10_a: assert property (
        pixelStrobe ##1 (!pixelStrobe)[*8] ##1 (!pixelStrobe)[*2]
        |=> !ctrlLane)
        else $error("control bit10 not zero");
    lanes_idle_a: assert property (sinceStb_q >= 5'h0E |->
        !forwardedDdrClock && !ctrlLane && dataLane == 16'h0000)
        else $error("lanes active after word end");
    train_reg_a: assert property (
        regWrEn && regAddr == `SOFC_ADDR_TRAIN_LO ##1
        !regWrEn && $stable(regAddr) |=> regRdData == $past(regWrData, 2))
        else $error("training low byte readback wrong");
    tpin_reg_a: assert property (
        regWrEn && regAddr == `SOFC_ADDR_TPIN2_SEL ##1
        !regWrEn && $stable(regAddr) |=> regRdData == $past(regWrData, 2))
        else $error("test select readback wrong");
    unmapped_a: assert property (!(regAddr inside {`SOFC_ADDR_TRAIN_LO,
        `SOFC_ADDR_TRAIN_HI, `SOFC_ADDR_TPIN1_SEL, `SOFC_ADDR_TPIN2_SEL})
        |=> regRdData == 8'h00)
        else $error("unmapped address read nonzero");
endmodule
bind sofc_formatter sofc_formatter_checker i_chk (.clk_sys, .nrst,
    .regWrEn, .regAddr, .regWrData, .regRdData, .dataLane, .ctrlLane,
    .forwardedDdrClock, .pixelStrobe);

// file: tb/sofc_formatter_tb.sv
/* Testbench of the formatter: registers, idle word, all channel modes at 10 bits,
   modes 16 and 2 at 12 bits. Assumes the receiver model and the bound checker. */
`timescale 1ns/1ps
`include "sofc_regs.vh"
module sofc_formatter_tb;
    localparam ROWS = 3;
    localparam BL   = 8;
    reg          clk_sys = 1'b0;
    reg          nrst = 1'b0;
    reg          pixClkIn = 1'b0;
    reg  [1:0]   chanMode = 2'h0;
    reg          pixel12 = 1'b0;
    reg          frameReq = 1'b0;
    reg  [2:0]   stat = 3'h0;
    reg  [191:0] pixIn = {192{1'b0}};
    reg          regWrEn = 1'b0;
    reg  [6:0]   regAddr = 7'h00;
    reg  [7:0]   regWrData = 8'h00;
    wire [7:0]   regRdData;
    wire [15:0]  dataLane;
    wire         ctrlLane, ddrClk, tpA, tpB, pixelStrobe;
    wire [203:0] words;
    wire         wordDone, phaseOk;
    integer      seed = 11768;
    integer      num_errors = 0;
    integer      cmp_count = 0;
    integer      pixHalf = 200;
    integer      i;
    integer      k;
    reg  [11:0]  train = `SOFC_RST_TRAIN;
    reg  [11:0]  cw, nD, nS, nR;
    reg  [7:0]   selA = 8'h00;
    reg  [7:0]   selB = 8'h00;
    reg  [1:0]   m;
    reg          chk = 1'b0;
    reg          seenF = 1'b0;
    reg          done = 1'b0;

    always #25 clk_sys = ~clk_sys;
    // Offset start keeps pixel edges off the system clock grid
    initial #7 forever #(pixHalf) pixClkIn = ~pixClkIn;

    sofc_formatter #(.ROWS(ROWS), .BURST_LEN(BL)) i_sofc_formatter (
        .clk_sys, .nrst, .pixClkIn, .chanMode, .pixel12, .frameReq,
        .fotActive(stat[0]), .integratingBlockA(stat[1]),
        .integratingBlockB(stat[2]), .pixIn, .regWrEn, .regAddr,
        .regWrData, .regRdData, .dataLane, .ctrlLane,
        .forwardedDdrClock(ddrClk), .testOutPinA(tpA),
        .testOutPinB(tpB), .pixelStrobe);
    sofc_rx_model i_sofc_rx_model (.clk_sys, .pixelStrobe, .ddrClk,
        .dataLane, .ctrlLane, .words, .wordDone, .phaseOk,
        .wordLen(pixel12 ? `SOFC_LEN12 : `SOFC_LEN10));

    function [1:0] effMode(input [1:0] md, input p);
        effMode = (p && md != `SOFC_MODE_2) ? `SOFC_MODE_4 : md;
    endfunction
    // Codes above four leave the pin low
    function selBit(input [7:0] s, input [11:0] w);
        selBit = (s > 8'h04) ? 1'b0 : w[(s < 2) ? s + 6 : s - 2];
    endfunction

    task check(input [11:0] got, input [11:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        begin
            @(negedge clk_sys);
            regWrEn = 1'b1;
            regAddr = a;
            regWrData = d;
            @(negedge clk_sys);
            regWrEn = 1'b0;
        end
    endtask
    task rd(input [6:0] a, input [7:0] exp);
        begin
            @(negedge clk_sys);
            regAddr = a;
            repeat (2) @(negedge clk_sys);
            check(regRdData, exp);
        end
    endtask

    // Judge each received word against the settings of this frame
    always @(negedge clk_sys) if (wordDone && chk) begin
        cw = words[203:192];
        m = effMode(chanMode, pixel12);
        check(cw & 12'hF00, 12'h200);
        check(cw[7:5], stat & {~stat[0], ~stat[0], 1'b1});
        check((cw[0] & ~cw[1]) | (cw[1] & ~cw[2]), 12'h000);
        if (!cw[2] && stat == 3'h0)
            check(cw, `SOFC_CTRL_IDLE);
        check(phaseOk, 12'h001);
        check(tpA, selBit(selA, cw));
        check(tpB, selBit(selB, cw));
        for (i = 0; i < 16; i = i + 1)
            check(words[i*12+:12], (cw[0] ? pixIn[(i & ~((1 << m) - 1))*12+:12]
                : train) & (pixel12 ? 12'hFFF : 12'h3FF));
        nD = nD + cw[0];
        nS = nS + cw[3];
        nR = nR + cw[4];
        done = done | (seenF & ~cw[2]);
        seenF = seenF | cw[2];
        // Fresh pixels per period; next strobe is still cycles away
        for (i = 0; i < 6; i = i + 1)
            pixIn[i*32+:32] = $random(seed);
    end

    // One frame with fresh random pixels, training word, selects, and status unless mode 16
    task frame(input [1:0] md, input p12);
        integer  n;
        reg [1:0] fm;
        begin
            chk = 1'b0;
            chanMode = md;
            pixel12 = p12;
            fm = effMode(md, p12);
            stat = (md == 2'h0) ? 3'h0 : $random(seed);
            selA = {$random(seed)} % 6;
            selB = {$random(seed)} % 6;
            train = $random(seed);
            for (n = 0; n < 6; n = n + 1)
                pixIn[n*32+:32] = $random(seed);
            wr(`SOFC_ADDR_TRAIN_LO, train[7:0]);
            wr(`SOFC_ADDR_TRAIN_HI, {4'h0, train[11:8]});
            wr(`SOFC_ADDR_TPIN1_SEL, selA);
            wr(`SOFC_ADDR_TPIN2_SEL, selB);
            repeat (40) @(negedge clk_sys);
            nD = 12'h000;
            nS = 12'h000;
            nR = 12'h000;
            seenF = 1'b0;
            done = 1'b0;
            chk = 1'b1;
            frameReq = 1'b1;
            @(negedge clk_sys);
            frameReq = 1'b0;
            for (n = 0; n < 8000 && !done; n = n + 1)
                @(negedge clk_sys);
            check(done, 12'h001);
            check(nD, (ROWS * BL) << fm);
            check(nS, ROWS << fm);
            check(nR, ROWS);
            $display("frame mode %0d width12 %0d ended", md, p12);
        end
    endtask

    task conclude;
        begin
            $display("compares %0d mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // Hang guard, well beyond the six frames
    initial begin
        #3000000;
        num_errors = num_errors + 1;
        conclude;
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        rd(`SOFC_ADDR_TRAIN_LO, `SOFC_RST_TRAIN & 12'h0FF);
        rd(`SOFC_ADDR_TPIN1_SEL, `SOFC_RST_TPIN_SEL);
        wr(`SOFC_ADDR_TPIN1_SEL, 8'hA5);
        rd(`SOFC_ADDR_TPIN1_SEL, 8'hA5);
        rd(7'h33, 8'h00);
        $display("register test ended");
        pixHalf = 450;
        for (k = 0; k < 4; k = k + 1)
            frame(k[1:0], 1'b0);
        frame(`SOFC_MODE_16, 1'b1);
        frame(`SOFC_MODE_2, 1'b1);
        conclude;
    end
endmodule

// file: tb/sofc_rx_model.sv
/* Receiver model: deserialises 16 data lanes and the control lane.
   Assumes bit0 arrives one cycle after the pixel strobe, LSB first. */
`timescale 1ns/1ps
module sofc_rx_model (
    input  wire         clk_sys,
    input  wire         pixelStrobe,
    input  wire         ddrClk,
    input  wire [15:0]  dataLane,
    input  wire         ctrlLane,
    input  wire [3:0]   wordLen,
    output reg  [203:0] words = {204{1'b0}},
    output reg          wordDone = 1'b0,
    output reg          phaseOk = 1'b0
);
    reg [3:0]   bitIdx = 4'hF;
    reg [203:0] acc = {204{1'b0}};
    integer     i;
    // Word boundary from the strobe; control word kept in slot 16
    always @(posedge clk_sys) begin
        wordDone <= 1'b0;
        if (pixelStrobe) begin
            bitIdx <= 4'h0;
            acc <= {204{1'b0}};
        end else if (bitIdx == wordLen) begin
            words <= acc;
            wordDone <= 1'b1;
            bitIdx <= 4'hF;
        end else if (bitIdx < wordLen) begin
            for (i = 0; i < 16; i = i + 1)
                acc[i*12+bitIdx] <= dataLane[i];
            acc[192+bitIdx] <= ctrlLane;
            if (bitIdx == 4'h0)
                phaseOk <= ddrClk;
            bitIdx <= bitIdx + 4'h1;
        end
    end
endmodule
